// >>> hdl/rlt_pkg.sv
// ****************************************
// shared constants of the periodic timers
// ****************************************
package rlt_pkg;

  // clock rates, for reference when converting slow cycles to core cycles
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned SLOW_CLK_HZ = 32_768;
  // least wait between two period settings, kept by software
  localparam int unsigned REWRITE_GAP_US = 100;
  localparam int unsigned REWRITE_GAP_SLOW_CYC = 3;

  // ****************************************
  // register indices and byte addresses
  // ****************************************
  localparam logic [31:0] IDX_T1_PER_LO = 32'h0b00_00d0;
  localparam logic [31:0] IDX_T1_PER_HI = 32'h0b00_00d2;
  localparam logic [31:0] IDX_T1_CNT_LO = 32'h0b00_00d4;
  localparam logic [31:0] IDX_T1_CNT_HI = 32'h0b00_00d6;
  localparam logic [31:0] IDX_T2_PER_LO = 32'h0b00_00d8;
  localparam logic [31:0] IDX_IRQ_STAT = 32'h0b00_00e0;
  localparam logic [31:0] IDX_IRQ_MASK = 32'h0b00_00e2;

  localparam logic [31:0] ADDR_T1_PER_LO = {IDX_T1_PER_LO[29:0], 2'b00};
  localparam logic [31:0] ADDR_T1_PER_HI = {IDX_T1_PER_HI[29:0], 2'b00};
  localparam logic [31:0] ADDR_T1_CNT_LO = {IDX_T1_CNT_LO[29:0], 2'b00};
  localparam logic [31:0] ADDR_T1_CNT_HI = {IDX_T1_CNT_HI[29:0], 2'b00};
  localparam logic [31:0] ADDR_T2_PER_LO = {IDX_T2_PER_LO[29:0], 2'b00};
  localparam logic [31:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT[29:0], 2'b00};
  localparam logic [31:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[29:0], 2'b00};

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int PER_W = 24;
  localparam int LO_W = 16;
  localparam int HI_W = 8;
  localparam int STAT_T1_BIT = 0;
  localparam logic [15:0] PER_LO_RST = 16'h0000;
  localparam logic [7:0] PER_HI_RST = 8'h00;
  localparam logic [23:0] CNT_RST = 24'h00_0000;
  localparam logic [23:0] CNT_ONE = 24'h00_0001;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic {
    RLT_IDLE = 1'b0,
    RLT_ANSWER = 1'b1
  } rlt_bus_t;

endpackage

// >>> hdl/rlt_tick.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// slow clock pin to one-cycle tick
// ****************************************
module rlt_tick (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // slow clock pin
  input wire logic slow_clk_pin,
  // rising edge strobe
  output logic tick
);
  import rlt_pkg::*;

  logic sync1_reg, sync2_reg, sync3_reg, tick_reg;
  logic sync1_next, sync2_next, sync3_next, tick_next;

  // the first stage feeds only the second; the edge is taken between stages two and three
  always_comb begin
    sync1_next = slow_clk_pin;
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    tick_next = sync2_reg & ~sync3_reg;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// >>> hdl/rlt_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - the reload period is 24 bits, low 16 in one register and upper 8 in the low byte of another.
// - upper bits of the high period and high count registers read zero and ignore writes.
// - period registers clear on the rtc domain reset and hold their value across other resets.
// - once a new period is accepted the timer loads it and counts down from it.
// - a new period takes effect only after both period registers are written.
// - an accepted all-zero period stops the timer and raises no interrupt.
// - the running count decrements by one each slow clock cycle.
// - on the slow tick after the count reaches one, unless a new period loads on that tick, the timer raises its interrupt request.
// - on that interrupt the period is reloaded and counting goes on by itself.
// - the running count reads through two registers, low 16 bits and bits 23 to 16.
// - the second timer's low period bits live in their own read-write register.
// - the interrupt request is a flag held until software writes one to clear it.
module rlt_timer (
  // clock, resets, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sys_rst_n,
  input wire logic ce,
  // slow clock pin
  input wire logic slow_clk_pin,
  // avalon-mm slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);
  import rlt_pkg::*;

  // ****************************************
  // slow tick
  // ****************************************
  logic tick;

  rlt_tick rlt_tick_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .slow_clk_pin(slow_clk_pin),
    .tick(tick)
  );

  // ****************************************
  // bus slave
  // ****************************************
  rlt_bus_t state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next, rd_val;
  logic req, acc_wr, lane_lo, lane_hi;
  logic [15:0] per_lo_reg, per_lo_next;
  logic [7:0] per_hi_reg, per_hi_next;
  logic [15:0] t2_lo_reg, t2_lo_next;
  logic [23:0] cnt_reg, cnt_next, act_reg, act_next, stage_reg, stage_next;
  logic seen_lo_reg, seen_lo_next, seen_hi_reg, seen_hi_next, pend_reg, pend_next;
  logic flag_reg, flag_next, mask_reg, mask_next, evt;

  assign req = avs_read | avs_write;
  assign acc_wr = avs_write & (state_reg == RLT_ANSWER);
  assign lane_lo = avs_byteenable[0];
  assign lane_hi = avs_byteenable[1];

  // reads are live: no snapshot of the count, so a read can tear across a tick
  always_comb begin
    if (avs_address == ADDR_T1_PER_LO) begin
      rd_val = {16'h0000, per_lo_reg};
    end else if (avs_address == ADDR_T1_PER_HI) begin
      rd_val = {24'h00_0000, per_hi_reg};
    end else if (avs_address == ADDR_T1_CNT_LO) begin
      rd_val = {16'h0000, cnt_reg[15:0]};
    end else if (avs_address == ADDR_T1_CNT_HI) begin
      rd_val = {24'h00_0000, cnt_reg[23:16]};
    end else if (avs_address == ADDR_T2_PER_LO) begin
      rd_val = {16'h0000, t2_lo_reg};
    end else if (avs_address == ADDR_IRQ_STAT) begin
      rd_val = {31'h0000_0000, flag_reg};
    end else if (avs_address == ADDR_IRQ_MASK) begin
      rd_val = {31'h0000_0000, mask_reg};
    end else begin
      rd_val = RDATA_RST;
    end
  end

  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    case (state_reg)
      RLT_IDLE: begin
        if (req) begin
          state_next = RLT_ANSWER;
          rdata_next = avs_read ? rd_val : rdata_reg;
        end
      end
      RLT_ANSWER: begin
        state_next = RLT_IDLE;
      end
      default: begin
        state_next = RLT_IDLE;
      end
    endcase
    if (!sys_rst_n) begin
      state_next = RLT_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= RLT_IDLE;
      rdata_reg <= RDATA_RST;
    end else if (ce) begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = req & (state_reg == RLT_IDLE);

  // ****************************************
  // period registers and hand-off
  // ****************************************
  // system resets do not reach these; only nrst, the rtc domain reset, clears them
  always_comb begin
    per_lo_next = per_lo_reg;
    per_hi_next = per_hi_reg;
    t2_lo_next = t2_lo_reg;
    seen_lo_next = seen_lo_reg;
    seen_hi_next = seen_hi_reg;
    stage_next = stage_reg;
    pend_next = pend_reg;
    if (tick) begin
      pend_next = 1'b0;
    end
    if (acc_wr && avs_address == ADDR_T1_PER_LO) begin
      if (lane_lo) begin
        per_lo_next[7:0] = avs_writedata[7:0];
      end
      if (lane_hi) begin
        per_lo_next[15:8] = avs_writedata[15:8];
      end
      seen_lo_next = seen_lo_reg | lane_lo | lane_hi;
    end else if (acc_wr && avs_address == ADDR_T1_PER_HI) begin
      if (lane_lo) begin
        per_hi_next = avs_writedata[7:0];
      end
      seen_hi_next = seen_hi_reg | lane_lo;
    end else if (acc_wr && avs_address == ADDR_T2_PER_LO) begin
      if (lane_lo) begin
        t2_lo_next[7:0] = avs_writedata[7:0];
      end
      if (lane_hi) begin
        t2_lo_next[15:8] = avs_writedata[15:8];
      end
    end
    // a new period is staged only once both halves are in
    if (seen_lo_next && seen_hi_next) begin
      seen_lo_next = 1'b0;
      seen_hi_next = 1'b0;
      stage_next = {per_hi_next, per_lo_next};
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      per_lo_reg <= PER_LO_RST;
      per_hi_reg <= PER_HI_RST;
      t2_lo_reg <= PER_LO_RST;
      seen_lo_reg <= 1'b0;
      seen_hi_reg <= 1'b0;
      stage_reg <= CNT_RST;
      pend_reg <= 1'b0;
    end else if (ce) begin
      per_lo_reg <= per_lo_next;
      per_hi_reg <= per_hi_next;
      t2_lo_reg <= t2_lo_next;
      seen_lo_reg <= seen_lo_next;
      seen_hi_reg <= seen_hi_next;
      stage_reg <= stage_next;
      pend_reg <= pend_next;
    end
  end

  // ****************************************
  // countdown
  // ****************************************
  // a second setting inside three slow cycles simply replaces the staged value
  always_comb begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    evt = 1'b0;
    if (tick) begin
      if (pend_reg) begin
        act_next = stage_reg;
        cnt_next = stage_reg;
      end else if (act_reg == CNT_RST) begin
        cnt_next = cnt_reg;
      end else if (cnt_reg == CNT_ONE) begin
        cnt_next = act_reg;
        evt = 1'b1;
      end else begin
        cnt_next = cnt_reg - CNT_ONE;
      end
    end
  end

  // the count ignores sys_rst_n and runs on through system resets
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= CNT_RST;
      act_reg <= CNT_RST;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
    end
  end

  // ****************************************
  // interrupt flag and mask
  // ****************************************
  always_comb begin
    flag_next = flag_reg;
    mask_next = mask_reg;
    if (acc_wr && avs_address == ADDR_IRQ_STAT && lane_lo && avs_writedata[STAT_T1_BIT]) begin
      flag_next = 1'b0;
    end
    if (acc_wr && avs_address == ADDR_IRQ_MASK && lane_lo) begin
      mask_next = avs_writedata[STAT_T1_BIT];
    end
    // a new event in the clearing cycle wins
    if (evt) begin
      flag_next = 1'b1;
    end
    if (!sys_rst_n) begin
      mask_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else if (ce) begin
      flag_reg <= flag_next;
      mask_reg <= mask_next;
    end
  end

  assign irq = flag_reg & mask_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  count_step_a: assert property (
    ce && tick && !pend_reg && act_reg != CNT_RST && cnt_reg != CNT_ONE
    |=> cnt_reg == $past(cnt_reg) - CNT_ONE)
    else $error("count did not step down by one");

  stopped_hold_a: assert property (
    ce && tick && !pend_reg && act_reg == CNT_RST
    |=> $stable(cnt_reg) && !evt)
    else $error("zero period timer moved");

  reload_value_a: assert property (
    ce && tick && !pend_reg && act_reg != CNT_RST && cnt_reg == CNT_ONE
    |=> cnt_reg == $past(act_reg))
    else $error("count not reloaded at one");

  irq_raise_a: assert property (
    ce && tick && !pend_reg && act_reg != CNT_RST && cnt_reg == CNT_ONE
    |=> flag_reg)
    else $error("interrupt flag not raised at one");

  flag_hold_a: assert property (
    flag_reg && !(acc_wr && avs_address == ADDR_IRQ_STAT && lane_lo && avs_writedata[0])
    |=> flag_reg)
    else $error("flag dropped without a clear");

  flag_clear_a: assert property (
    ce && !evt && acc_wr && avs_address == ADDR_IRQ_STAT && lane_lo && avs_writedata[0]
    |=> !flag_reg)
    else $error("write of one did not clear flag");

  half_write_a: assert property (
    ce && !pend_reg && !seen_hi_reg && acc_wr && avs_address == ADDR_T1_PER_LO
    |=> !pend_reg ##1 $stable(act_reg) || tick)
    else $error("single half write staged a period");

  load_new_a: assert property (
    ce && tick && pend_reg
    |=> act_reg == $past(stage_reg) && cnt_reg == $past(stage_reg))
    else $error("staged period not loaded");

  stage_both_a: assert property (
    ce && acc_wr && avs_address == ADDR_T1_PER_HI && lane_lo && seen_lo_reg
    |=> pend_reg && stage_reg == {$past(avs_writedata[7:0]), $past(per_lo_reg)})
    else $error("full period not staged");

  hi_reserved_a: assert property (
    state_reg == RLT_ANSWER && avs_read && avs_address == ADDR_T1_CNT_HI
    |-> avs_readdata[31:8] == 24'h00_0000 && avs_readdata[7:0] == $past(cnt_reg[23:16]))
    else $error("count high read wrong");

  cnt_read_a: assert property (
    state_reg == RLT_ANSWER && avs_read && avs_address == ADDR_T1_CNT_LO
    |-> avs_readdata == {16'h0000, $past(cnt_reg[15:0])})
    else $error("count low read wrong");

endmodule
`default_nettype wire

// >>> verification/rlt_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// self-checking bench for the periodic timer
// ****************************************
module rlt_timer_tb;
  import rlt_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sys_rst_n = 1'b1;
  logic ce = 1'b1;
  logic slow_clk_pin = 1'b0;
  logic [31:0] avs_address = 32'h0000_0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [31:0] addrs [8] = '{ADDR_T1_PER_LO, ADDR_T1_PER_HI, ADDR_T1_CNT_LO, ADDR_T1_CNT_HI,
    ADDR_T2_PER_LO, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 32'h2C00_03F0};

  rlt_timer rlt_timer_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .sys_rst_n(sys_rst_n),
    .ce(ce),
    .slow_clk_pin(slow_clk_pin),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq)
  );

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // a hung handshake must not stall the run forever
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      $display("BAD run_length expected below 5000 seen %0d", cycles);
      report_and_stop();
    end
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // the request stands until waitrequest is seen low at a rising edge; read data
  // is taken at that same edge; only the bench timeout ends a hung wait
  task automatic bus(input logic rd, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= ~rd;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
    bus(1'b1, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge core_clk);
    chk("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq});
  endtask

  // slow pin runs far faster than 32.768 kHz to keep the run short; one call, n ticks
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      slow_clk_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      slow_clk_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], 32'h0000_0000, "reset_value");
    $display("test reset_values done");

    wr(ADDR_T1_PER_HI, 32'h0000_FFFF);
    rd(ADDR_T1_PER_HI, 32'h0000_00FF, "per_hi_reserved");
    tick(2);
    rd(ADDR_T1_CNT_LO, 32'h0000_0000, "cnt_half_write");
    wr(ADDR_T1_PER_LO, 32'h0000_0010);
    tick(1);
    rd(ADDR_T1_CNT_LO, 32'h0000_0010, "cnt_lo_load");
    rd(ADDR_T1_CNT_HI, 32'h0000_00FF, "cnt_hi_load");
    tick(1);
    rd(ADDR_T1_CNT_LO, 32'h0000_000F, "cnt_decrement");
    wr(ADDR_T1_CNT_LO, 32'h0000_1234);
    rd(ADDR_T1_CNT_LO, 32'h0000_000F, "cnt_read_only");
    $display("test load_and_count done");

    tick(2);
    wr(ADDR_T1_PER_LO, 32'h0000_0006);
    wr(ADDR_T1_PER_HI, 32'h0000_0000);
    tick(6);
    rd(ADDR_T1_CNT_LO, 32'h0000_0001, "cnt_at_one");
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "stat_before");
    tick(1);
    rd(ADDR_T1_CNT_LO, 32'h0000_0006, "cnt_reload");
    rd(ADDR_IRQ_STAT, 32'h0000_0001, "stat_set");
    chk_irq(1'b0);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    chk_irq(1'b1);
    wr(ADDR_IRQ_STAT, 32'h0000_0001);
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "stat_cleared");
    chk_irq(1'b0);
    tick(6);
    rd(ADDR_IRQ_STAT, 32'h0000_0001, "stat_periodic");
    chk_irq(1'b1);
    $display("test periodic_irq done");

    @(posedge core_clk);
    sys_rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    sys_rst_n <= 1'b1;
    rd(ADDR_IRQ_MASK, 32'h0000_0000, "mask_sys_reset");
    chk_irq(1'b0);
    rd(ADDR_T1_PER_LO, 32'h0000_0006, "per_kept");
    rd(ADDR_IRQ_STAT, 32'h0000_0001, "stat_kept");
    rd(ADDR_T1_CNT_LO, 32'h0000_0006, "cnt_kept");
    tick(1);
    rd(ADDR_T1_CNT_LO, 32'h0000_0005, "cnt_runs_on");
    rd(ADDR_T1_CNT_LO, 32'h0000_0005, "cnt_read_twice");
    // with the enable low the slow edges must leave the count alone
    @(posedge core_clk);
    ce <= 1'b0;
    tick(2);
    ce <= 1'b1;
    rd(ADDR_T1_CNT_LO, 32'h0000_0005, "cnt_frozen");
    $display("test system_reset done");

    wr(ADDR_T1_PER_LO, 32'h0000_0000);
    wr(ADDR_T1_PER_HI, 32'h0000_0000);
    wr(ADDR_IRQ_STAT, 32'h0000_0001);
    tick(9);
    rd(ADDR_T1_CNT_LO, 32'h0000_0000, "cnt_stopped");
    rd(ADDR_IRQ_STAT, 32'h0000_0000, "stat_stopped");
    $display("test zero_period done");

    wr(ADDR_T2_PER_LO, 32'h0000_A5C3);
    rd(ADDR_T2_PER_LO, 32'h0000_A5C3, "t2_per_lo");
    wr(ADDR_T1_PER_LO, 32'h0000_1234);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rd(ADDR_T2_PER_LO, 32'h0000_0000, "t2_rtc_reset");
    rd(ADDR_T1_PER_LO, 32'h0000_0000, "per_rtc_reset");
    $display("test rtc_reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
